// >>> src/mic_aneg_gate.sv
// converter start gate for twisted-pair auto-negotiation
`timescale 1ns/1ps
`default_nettype none
module mic_aneg_gate
  import mic_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    resetn_i,
  input  wire mic_if_t if_kind_i,
  input  wire logic    fiber_signal_i,
  input  wire logic    fiber_aneg_ok_i,
  output logic         tp_aneg_start_o
);

  // converter modes start only while their fiber condition holds, loss drops it; all other kinds hold start high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tp_aneg_start_o <= 1'b0;
    end else begin
      case (if_kind_i)
        MIC_IF_CONV_NOANEG: tp_aneg_start_o <= fiber_signal_i;   // RULE14
        MIC_IF_CONV_ANEG:   tp_aneg_start_o <= fiber_aneg_ok_i;  // RULE15
        default:            tp_aneg_start_o <= 1'b1;
      endcase
    end
  end

  a_conv_sig: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (if_kind_i == MIC_IF_CONV_NOANEG && !fiber_signal_i) |=> !tp_aneg_start_o) else $error("aneg w/o signal");  // RULE14
  a_conv_aneg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (if_kind_i == MIC_IF_CONV_ANEG && !fiber_aneg_ok_i) |=> !tp_aneg_start_o) else $error("aneg w/o fiber ok");  // RULE15

endmodule
`default_nettype wire

// >>> src/mic_cs_sel.sv
// carrier-sense source selection for the mac side
`timescale 1ns/1ps
`default_nettype none
module mic_cs_sel
  import mic_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] cs_sel_i,
  input  wire logic       full_duplex_i,
  input  wire logic       tx_active_i,
  input  wire logic       rx_active_i,
  output logic            carrier_sense_o
);

  logic cs_d;  // next carrier-sense level

  // pick the sources per duplex mode
  always_comb begin
    cs_d = 1'b0;
    case (cs_sel_i)
      MIC_CS_BOTH_THEN_RX:  cs_d = full_duplex_i ? rx_active_i : (tx_active_i | rx_active_i);  // RULE8
      MIC_CS_BOTH_THEN_LOW: cs_d = full_duplex_i ? 1'b0 : (tx_active_i | rx_active_i);         // RULE8
      MIC_CS_RX_RX:         cs_d = rx_active_i;                                                // RULE8
      default:              cs_d = full_duplex_i ? 1'b0 : rx_active_i;                         // RULE8
    endcase
  end

  // registered so the carrier-sense output is glitch free
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      carrier_sense_o <= 1'b0;
    end else begin
      carrier_sense_o <= cs_d;
    end
  end

  a_cs_fdx_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (full_duplex_i && cs_sel_i[0]) |=> !carrier_sense_o) else $error("cs not low in fdx");  // RULE8

endmodule
`default_nettype wire

// >>> src/mic_pkg.sv
// package: register layout, reset values, field codes and carriers for the mac interface control block
package mic_pkg;

  // register index in the management space (offset not printed, chosen locally)
  localparam logic [4:0]  MIC_REG_OFFSET    = 5'h17;
  // reset value loaded by the async reset, replaced by the strap image and skew straps one edge after release
  localparam logic [15:0] MIC_RESET_VALUE   = 16'h8000;

  // field positions
  localparam int MIC_RXC_KEEP_BIT  = 15;
  localparam int MIC_RXDLY_LSB     = 12;
  localparam int MIC_SUPPLY_BIT    = 11;
  localparam int MIC_TXDLY_LSB     = 8;
  localparam int MIC_CS_LSB        = 6;
  localparam int MIC_TOPO_LSB      = 4;
  localparam int MIC_MODE_LSB      = 0;

  // delay step in picoseconds per code
  localparam int MIC_DELAY_STEP_PS = 500;

  // carrier-sense source codes
  localparam logic [1:0] MIC_CS_BOTH_THEN_RX  = 2'h0;
  localparam logic [1:0] MIC_CS_BOTH_THEN_LOW = 2'h1;
  localparam logic [1:0] MIC_CS_RX_RX         = 2'h2;
  localparam logic [1:0] MIC_CS_RX_LOW        = 2'h3;

  // topology codes
  localparam logic [1:0] MIC_TOPO_COPPER      = 2'h0;
  localparam logic [1:0] MIC_TOPO_FIBER       = 2'h1;
  localparam logic [1:0] MIC_TOPO_DUAL_MEDIA  = 2'h2;
  localparam logic [1:0] MIC_TOPO_CONVERTER   = 2'h3;

  // mode codes
  localparam logic [3:0] MIC_MODE_RGMII       = 4'h0;
  localparam logic [3:0] MIC_MODE_SGMII       = 4'h1;
  localparam logic [3:0] MIC_MODE_RMII        = 4'h2;
  localparam logic [3:0] MIC_MODE_GMII        = 4'h4;
  localparam logic [3:0] MIC_MODE_SGMII_NC    = 4'h6;
  localparam logic [3:0] MIC_MODE_TEST        = 4'hF;
  localparam logic [3:0] MIC_MODE_CONV_NOANEG = 4'h0;
  localparam logic [3:0] MIC_MODE_CONV_ANEG   = 4'h1;

  // decoded interface kind
  typedef enum logic [3:0] {
    MIC_IF_RGMII,
    MIC_IF_SGMII,
    MIC_IF_RMII,
    MIC_IF_GMII,
    MIC_IF_SGMII_NC,
    MIC_IF_SGMII_TEST,
    MIC_IF_FIBER_RGMII,
    MIC_IF_DUAL_RGMII,
    MIC_IF_CONV_NOANEG,
    MIC_IF_CONV_ANEG,
    MIC_IF_RESERVED
  } mic_if_t;

  // register fields as a carrier
  typedef struct packed {
    logic       rx_clock_linkdown_keep;
    logic [2:0] rx_clock_delay_sel;
    logic       pin_supply_sel;
    logic [2:0] tx_clock_delay_sel;
    logic [1:0] cs_sel;
    logic [1:0] topology;
    logic [3:0] mode;
  } mic_ctrl_t;

  // strap inputs sampled at reset release
  typedef struct packed {
    logic       eeprom_mode;
    logic [2:0] rx_delay;
    logic [2:0] tx_delay;
    logic [15:0] image;
  } mic_strap_t;

  // decode mode field against topology
  function automatic mic_if_t mic_decode(input logic [1:0] topo, input logic [3:0] mode);
    mic_if_t r;
    r = MIC_IF_RESERVED;
    case (topo)
      MIC_TOPO_COPPER: begin
        case (mode)
          MIC_MODE_RGMII:    r = MIC_IF_RGMII;
          MIC_MODE_SGMII:    r = MIC_IF_SGMII;
          MIC_MODE_RMII:     r = MIC_IF_RMII;
          MIC_MODE_GMII:     r = MIC_IF_GMII;
          MIC_MODE_SGMII_NC: r = MIC_IF_SGMII_NC;
          MIC_MODE_TEST:     r = MIC_IF_SGMII_TEST;
          default:           r = MIC_IF_RESERVED;
        endcase
      end
      MIC_TOPO_FIBER:      r = (mode == MIC_MODE_RGMII) ? MIC_IF_FIBER_RGMII : MIC_IF_RESERVED;
      MIC_TOPO_DUAL_MEDIA: r = (mode == MIC_MODE_RGMII) ? MIC_IF_DUAL_RGMII : MIC_IF_RESERVED;
      default: begin
        if (mode == MIC_MODE_CONV_NOANEG) begin
          r = MIC_IF_CONV_NOANEG;
        end else if (mode == MIC_MODE_CONV_ANEG) begin
          r = MIC_IF_CONV_ANEG;
        end
      end
    endcase
    return r;
  endfunction

endpackage

// >>> src/mic_top.sv
// mac interface control register and its decoded interface settings
// How it works
// (RULE1) no eeprom: straps fill register, writes ignored; code still stores them for readback, not applied
// (RULE2) eeprom mode: writes stored and applied
// (RULE3) bit15 keeps rx clock on link down
// (RULE4) bits14:12 rx delay, 0.5 ns steps
// (RULE5) skew reset values come from straps
// (RULE6) bits10:8 tx delay, 0.5 ns steps
// (RULE7) bit11 pin supply: 0 3.3V, 1 2.5V
// (RULE8) bits7:6 choose carrier-sense sources
// (RULE9) bits5:4 choose data-flow topology
// (RULE10) mode field decoded per topology
// (RULE11) copper mode codes, 0011/0101 reserved
// (RULE12) fiber 0000 rgmii to 1000base-x, 1000 forced
// (RULE13) dual media 0000 rgmii, others reserved
// (RULE14) converter 0000 waits fiber signal detect
// (RULE15) converter 0001 waits fiber negotiation success
// (RULE16) software avoids reserved mode codes
// (RULE17) fields read back last stored value
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mic_top
  import mic_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  // strap pins, sampled once after reset release
  input  wire logic        strap_eeprom_mode_i,
  input  wire logic [15:0] strap_image_i,
  input  wire logic [2:0]  strap_rx_delay_i,
  input  wire logic [2:0]  strap_tx_delay_i,
  // link and datapath status
  input  wire logic        link_up_i,
  input  wire logic        full_duplex_i,
  input  wire logic        tx_active_i,
  input  wire logic        rx_active_i,
  input  wire logic        fiber_signal_i,
  input  wire logic        fiber_aneg_ok_i,
  // applied settings
  output logic             rx_clock_enable_o,
  output logic [2:0]       rx_clock_delay_sel_o,
  output logic [2:0]       tx_clock_delay_sel_o,
  output logic             pin_supply_sel_o,
  output logic [1:0]       topology_o,
  output mic_if_t          if_kind_o,
  output logic             force_1000_o,
  output logic             limit_10_100_o,
  output logic             mode_reserved_o,
  output logic             carrier_sense_o,
  output logic             tp_aneg_start_o
);

  mic_ctrl_t ctrl_q;        // stored register content, what software reads
  mic_ctrl_t applied_q;     // settings driving operation
  logic      eeprom_q;      // latched operating mode
  logic      strap_done_q;  // straps have been captured
  logic      hit_wr;        // write to this register
  logic      hit_rd;        // read of this register
  mic_if_t   kind;          // decoded interface kind of applied settings

  assign hit_wr = reg_wr_i && (reg_addr_i == MIC_REG_OFFSET);
  assign hit_rd = reg_rd_i && (reg_addr_i == MIC_REG_OFFSET);

  // strap capture one edge after reset release; async reset loads constants only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_q <= 1'b0;
      eeprom_q     <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      eeprom_q     <= strap_eeprom_mode_i;
    end
  end

  // stored register: straps first, then software writes stick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= mic_ctrl_t'(MIC_RESET_VALUE);
    end else if (!strap_done_q) begin
      ctrl_q <= mic_ctrl_t'(strap_image_i);                     // RULE1
      ctrl_q.rx_clock_delay_sel <= strap_rx_delay_i;            // RULE5
      ctrl_q.tx_clock_delay_sel <= strap_tx_delay_i;            // RULE5
    end else if (hit_wr) begin
      ctrl_q <= mic_ctrl_t'(reg_wdata_i);                       // RULE17
    end
  end

  // applied copy: follows writes only in eeprom mode, so strap mode ignores them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      applied_q <= mic_ctrl_t'(MIC_RESET_VALUE);
    end else if (!strap_done_q) begin
      applied_q <= mic_ctrl_t'(strap_image_i);                  // RULE1
      applied_q.rx_clock_delay_sel <= strap_rx_delay_i;         // RULE5
      applied_q.tx_clock_delay_sel <= strap_tx_delay_i;         // RULE5
    end else if (hit_wr && eeprom_q) begin
      applied_q <= mic_ctrl_t'(reg_wdata_i);                    // RULE2
    end
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (hit_rd) begin
      reg_rdata_o <= 16'(ctrl_q);                               // RULE17
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // mode field meaning depends on topology; reserved codes flagged, not trusted
  assign kind = mic_decode(applied_q.topology, applied_q.mode);  // RULE10 RULE11 RULE12 RULE13

  // registered settings outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_clock_enable_o    <= 1'b0;
      rx_clock_delay_sel_o <= 3'h0;
      tx_clock_delay_sel_o <= 3'h0;
      pin_supply_sel_o     <= 1'b0;
      topology_o           <= MIC_TOPO_COPPER;
      if_kind_o            <= MIC_IF_RGMII;
      force_1000_o         <= 1'b0;
      limit_10_100_o       <= 1'b0;
      mode_reserved_o      <= 1'b0;
    end else begin
      rx_clock_enable_o    <= link_up_i | applied_q.rx_clock_linkdown_keep;  // RULE3
      rx_clock_delay_sel_o <= applied_q.rx_clock_delay_sel;                  // RULE4
      tx_clock_delay_sel_o <= applied_q.tx_clock_delay_sel;                  // RULE6
      pin_supply_sel_o     <= applied_q.pin_supply_sel;                      // RULE7
      topology_o           <= applied_q.topology;                            // RULE9
      if_kind_o            <= kind;
      force_1000_o         <= (kind == MIC_IF_FIBER_RGMII);                  // RULE12
      limit_10_100_o       <= (kind == MIC_IF_RMII);                         // RULE11
      mode_reserved_o      <= (kind == MIC_IF_RESERVED);                     // RULE16
    end
  end

  // carrier-sense selection
  mic_cs_sel u_cs (
    .clk_i           (clk_i),
    .resetn_i        (resetn_i),
    .cs_sel_i        (applied_q.cs_sel),
    .full_duplex_i   (full_duplex_i),
    .tx_active_i     (tx_active_i),
    .rx_active_i     (rx_active_i),
    .carrier_sense_o (carrier_sense_o)
  );

  // converter auto-negotiation gate
  mic_aneg_gate u_aneg (
    .clk_i           (clk_i),
    .resetn_i        (resetn_i),
    .if_kind_i       (kind),
    .fiber_signal_i  (fiber_signal_i),
    .fiber_aneg_ok_i (fiber_aneg_ok_i),
    .tp_aneg_start_o (tp_aneg_start_o)
  );

  a_strap_ignore: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (strap_done_q && !eeprom_q && hit_wr) |=> $stable(applied_q)) else $error("write changed strap mode");  // RULE1
  a_eeprom_apply: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (strap_done_q && eeprom_q && hit_wr) |=> (16'(applied_q) == $past(reg_wdata_i))) else $error("write not applied");  // RULE2
  a_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (strap_done_q && hit_wr) ##1 hit_rd |=> (reg_rdata_o == $past(reg_wdata_i, 2))) else $error("readback wrong");  // RULE17
  a_rxclk_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!link_up_i && !applied_q.rx_clock_linkdown_keep) |=> !rx_clock_enable_o) else $error("rx clock on");  // RULE3
  a_rx_delay: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> (rx_clock_delay_sel_o == $past(applied_q.rx_clock_delay_sel))) else $error("rx delay");  // RULE4
  a_tx_delay: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> (tx_clock_delay_sel_o == $past(applied_q.tx_clock_delay_sel))) else $error("tx delay");  // RULE6
  a_strap_skew: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(strap_done_q) |-> (ctrl_q.rx_clock_delay_sel == $past(strap_rx_delay_i))) else $error("skew strap");  // RULE5
  a_fiber_force: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (applied_q.topology == MIC_TOPO_FIBER && applied_q.mode == 4'h0) |=> force_1000_o) else $error("no force");  // RULE12
  a_copper_res: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (applied_q.topology == MIC_TOPO_COPPER && applied_q.mode == 4'h3) |=> mode_reserved_o) else $error("reserved");  // RULE11

endmodule
`default_nettype wire

// >>> testbench/mic_mac_model.sv
// far-side model: link, duplex, activity and fiber status levels seen by the control block
`timescale 1ns/1ps
`default_nettype none
module mic_mac_model (
  input  wire logic clk_i,
  output logic      link_up_o,
  output logic      full_duplex_o,
  output logic      tx_active_o,
  output logic      rx_active_o,
  output logic      fiber_signal_o,
  output logic      fiber_aneg_ok_o
);
  logic [5:0] lines_q; // pending levels: link, duplex, tx, rx, fiber signal, fiber negotiation
  initial lines_q = 6'h00;
  // levels are steady outside the launch edge, so the block never samples a moving line
  assign {link_up_o, full_duplex_o, tx_active_o, rx_active_o, fiber_signal_o, fiber_aneg_ok_o} = lines_q;
  // change all levels together just after a rising edge
  task automatic set_lines(input logic [5:0] v);
    @(posedge clk_i);
    lines_q <= v;
  endtask
endmodule
`default_nettype wire

// >>> testbench/mic_top_tb.sv
// self-checking bench for the mac interface control block
`timescale 1ns/1ps
`default_nettype none
module mic_top_tb;
  import mic_pkg::*;
  logic        clk     = 1'b0;  // 10 MHz clock
  logic        resetn  = 1'b0;  // active-low reset
  logic [4:0]  addr    = 5'h00; // register index
  logic [15:0] wdata   = 16'h0000;
  logic        wr_s    = 1'b0;  // write strobe
  logic        rd_s    = 1'b0;  // read strobe
  logic        ee_mode = 1'b1;  // strap: eeprom mode
  logic [15:0] image   = 16'h0000;
  logic [2:0]  s_rx    = 3'h0;
  logic [2:0]  s_tx    = 3'h0;
  logic [15:0] rdata;
  logic        link, fdx, txa, rxa, fsig, faok;
  logic        rxc_en, sup, f1000, lim, resv, crs, tp_start;
  logic [2:0]  rxd, txd;
  logic [1:0]  topo;
  mic_if_t     kind;
  int          n_errors   = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  mic_top u_mic_top (.clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .strap_eeprom_mode_i(ee_mode),
    .strap_image_i(image), .strap_rx_delay_i(s_rx), .strap_tx_delay_i(s_tx), .link_up_i(link),
    .full_duplex_i(fdx), .tx_active_i(txa), .rx_active_i(rxa), .fiber_signal_i(fsig),
    .fiber_aneg_ok_i(faok), .rx_clock_enable_o(rxc_en), .rx_clock_delay_sel_o(rxd),
    .tx_clock_delay_sel_o(txd), .pin_supply_sel_o(sup), .topology_o(topo), .if_kind_o(kind),
    .force_1000_o(f1000), .limit_10_100_o(lim), .mode_reserved_o(resv), .carrier_sense_o(crs),
    .tp_aneg_start_o(tp_start));

  mic_mac_model u_mic_mac_model (.clk_i(clk), .link_up_o(link), .full_duplex_o(fdx), .tx_active_o(txa),
    .rx_active_o(rxa), .fiber_signal_o(fsig), .fiber_aneg_ok_o(faok));

  // register-width comparison
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // decoded-setting comparison, up to four bits
  task automatic chk_out(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  // one-cycle read strobe; data only stand in the following cycle
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // outputs are registered one cycle behind the applied settings
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // write, read back, then let the settings reach the outputs
  task automatic wr_chk(input logic [15:0] d);
    logic [15:0] r;
    wr(MIC_REG_OFFSET, d);
    rd(MIC_REG_OFFSET, r);
    chk_reg("readback", d, r);
    settle();
  endtask
  task automatic do_reset(input logic ee, input logic [15:0] img, input logic [2:0] rx, input logic [2:0] tx);
    @(posedge clk);
    resetn  <= 1'b0;
    ee_mode <= ee;
    image   <= img;
    s_rx    <= rx;
    s_tx    <= tx;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // reference decode of the mode field against the topology
  function automatic mic_if_t exp_kind(input logic [1:0] t, input logic [3:0] m);
    if (t == 2'h0) begin
      case (m)
        4'h0: return MIC_IF_RGMII;
        4'h1: return MIC_IF_SGMII;
        4'h2: return MIC_IF_RMII;
        4'h4: return MIC_IF_GMII;
        4'h6: return MIC_IF_SGMII_NC;
        4'hF: return MIC_IF_SGMII_TEST;
        default: return MIC_IF_RESERVED;
      endcase
    end
    if (t == 2'h1) return (m == 4'h0) ? MIC_IF_FIBER_RGMII : MIC_IF_RESERVED;
    if (t == 2'h2) return (m == 4'h0) ? MIC_IF_DUAL_RGMII : MIC_IF_RESERVED;
    if (m == 4'h0) return MIC_IF_CONV_NOANEG;
    return (m == 4'h1) ? MIC_IF_CONV_ANEG : MIC_IF_RESERVED;
  endfunction

  // skew fields load from the straps on top of the image
  task automatic t_straps();
    logic [15:0] r;
    do_reset(1'b1, 16'h8000, 3'h5, 3'h3);
    rd(MIC_REG_OFFSET, r);
    chk_reg("strap value", 16'hD300, r);
    settle();
    chk_out("rx delay", 4'h5, {1'b0, rxd});
    chk_out("tx delay", 4'h3, {1'b0, txd});
  endtask
  // every delay code and both supply levels
  task automatic t_delays();
    for (int k = 0; k < 8; k++) begin
      wr_chk({1'b1, 3'(k), 1'(k), 3'(7 - k), 8'h00});
      chk_out("rx delay", 4'(k), {1'b0, rxd});
      chk_out("tx delay", 4'(7 - k), {1'b0, txd});
      chk_out("supply", 4'(k % 2), {3'h0, sup});
    end
  endtask
  // receive clock against link state and keep bit
  task automatic t_rxclk();
    for (int i = 0; i < 4; i++) begin
      wr_chk({1'(i / 2), 15'h0000});
      u_mic_mac_model.set_lines({1'(i), 5'h00});
      settle();
      chk_out("rx clock", 4'(i != 0), {3'h0, rxc_en});
    end
  endtask
  // carrier sense for each source code, duplex and activity combination
  task automatic t_cs();
    logic [1:0] c;
    logic       e;
    for (int ci = 0; ci < 4; ci++) begin
      c = 2'(ci);
      wr_chk({8'h80, c, 6'h00});
      for (int j = 0; j < 8; j++) begin
        u_mic_mac_model.set_lines({1'b1, 3'(j), 2'h0});
        settle();
        e = j[2] ? (!c[0] && j[0]) : (c[1] ? j[0] : (j[1] || j[0]));
        chk_out("carrier sense", {3'h0, e}, {3'h0, crs});
      end
    end
  endtask
  // full sweep, reserved codes included only to see them flagged
  task automatic t_decode();
    for (int t = 0; t < 4; t++) begin
      for (int m = 0; m < 16; m++) begin
        wr_chk({8'h80, 2'h0, 2'(t), 4'(m)});
        chk_out("topology", 4'(t), {2'h0, topo});
        chk_out("kind", exp_kind(2'(t), 4'(m)), kind);
        chk_out("reserved", 4'(exp_kind(2'(t), 4'(m)) == MIC_IF_RESERVED), {3'h0, resv});
        if (t < 2) begin
          chk_out("force 1000", 4'(t == 1 && m == 0), {3'h0, f1000});
          chk_out("limit 100", 4'(t == 0 && m == 2), {3'h0, lim});
        end
      end
    end
  endtask
  // converter start gates on fiber signal or fiber negotiation
  task automatic t_conv();
    for (int m = 0; m < 2; m++) begin
      wr_chk({8'h80, 4'h3, 4'(m)});
      for (int j = 0; j < 4; j++) begin
        u_mic_mac_model.set_lines({1'b1, 3'h0, 2'(j)});
        settle();
        chk_out("aneg start", 4'(m ? j[0] : j[1]), {3'h0, tp_start});
      end
    end
  endtask
  // neighbouring index: write ignored, read gives zero
  task automatic t_unmapped();
    logic [15:0] r;
    wr_chk(16'h5A31);
    wr(5'h16, 16'hFFFF);
    rd(5'h16, r);
    chk_reg("unmapped read", 16'h0000, r);
    rd(MIC_REG_OFFSET, r);
    chk_reg("after unmapped write", 16'h5A31, r);
  endtask
  // strap mode: straps set operation and software writes leave it alone
  task automatic t_strapmode();
    logic [15:0] r;
    do_reset(1'b0, 16'h0950, 3'h2, 3'h6);
    rd(MIC_REG_OFFSET, r);
    chk_reg("strap image", 16'h2E50, r);
    wr_chk(16'h8000);
    chk_out("rx delay", 4'h2, {1'b0, rxd});
    chk_out("tx delay", 4'h6, {1'b0, txd});
    chk_out("supply", 4'h1, {3'h0, sup});
    chk_out("topology", 4'h1, {2'h0, topo});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_straps();
    t_delays();
    t_rxclk();
    t_cs();
    t_decode();
    t_conv();
    t_unmapped();
    t_strapmode();
    finish_test();
  end
  // watchdog well beyond the roughly 820 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
